// ### hdl/capture_pkg.sv
/*
  Shared constants and types for the input capture channel: register
  offsets, control field positions, mode codes, channel states and the
  control field carrier.
  Assumes a 16-bit register port with a 4-bit word address.
*/
package capture_pkg;

  // Register port widths.
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;

  // Register word addresses.
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_BUFFER = 4'h1;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h2;
  localparam logic [3:0] ADDR_INT_CLEAR = 4'h3;
  localparam logic [3:0] ADDR_INT_ENABLE = 4'h4;

  // Control register field positions.
  localparam int IDLE_STOP_BIT = 13;
  localparam int TB_SEL_BIT = 7;
  localparam int CPI_LSB = 5;
  localparam int OV_BIT = 4;
  localparam int BNE_BIT = 3;
  localparam int MODE_LSB = 0;

  // Buffer depth and edge prescaler terminal counts.
  localparam int FIFO_DEPTH = 4;
  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hf;

  // Interrupt status bit positions.
  localparam int INT_W = 3;
  localparam int INT_CAPTURE = 0;
  localparam int INT_OVERFLOW = 1;
  localparam int INT_WAKE = 2;

  // Capture mode codes.
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_EVERY_EDGE = 3'h1,
    MODE_FALL = 3'h2,
    MODE_RISE = 3'h3,
    MODE_RISE4 = 3'h4,
    MODE_RISE16 = 3'h5,
    MODE_UNUSED = 3'h6,
    MODE_INT_PIN = 3'h7
  } mode_t;

  // Decoded channel state, one-hot.
  typedef enum logic [2:0] {
    CH_OFF = 3'b001,
    CH_CAPTURE = 3'b010,
    CH_INT_PIN = 3'b100
  } ch_state_t;

  // Software-writable control fields.
  typedef struct packed {
    logic idle_stop_select;
    logic timebase_select;
    logic [1:0] captures_per_interrupt;
    mode_t capture_mode_select;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{1'b0, 1'b0, 2'h0, MODE_OFF};

endpackage

// ### hdl/edge_prescaler.sv
/*
  Rising edge prescaler: emits a tick on every 4th or every 16th rise.
  Assumes rise is a one-cycle pulse from synchronised edge detection.
*/
`timescale 1ns/1ps
module edge_prescaler
  import capture_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic rise,
  input wire logic div16,
  output logic tick
);

  typedef struct packed {
    logic [3:0] count;
  } pre_state_t;

  pre_state_t state_reg;
  pre_state_t state_next;
  logic [3:0] last;

  // Terminal count follows the selected division.
  assign last = div16 ? PRE16_LAST : PRE4_LAST;
  assign tick = rise && !clear && (state_reg.count == last); // [RQ5]

  // A clear wins over an edge so a mode change starts a fresh count.
  always_comb begin
    state_next = state_reg;
    if (clear) begin
      state_next.count = 4'h0; // [RQ19]
    end else if (rise) begin
      state_next.count = tick ? 4'h0 : state_reg.count + 4'h1;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

endmodule

// ### hdl/input_capture_channel.sv
/*
  One input capture channel: pin synchroniser, edge detection, mode
  decode, 4-deep capture buffer, interrupt decimation, overflow and
  wake logic, register port and a masked interrupt output.
  Assumes both timebase counts are synchronous to clk, that the
  register strobes are one cycle wide and never both high, and that
  cpu_idle and cpu_sleep are levels from the power controller.
*/
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
//
// Function
// [RQ1] A qualifying event latches the full 16-bit count of the chosen timebase.
// [RQ2] Control bit 7 high selects the first timebase, low the second.
// [RQ3] Mode 001 captures on every rising and falling input edge.
// [RQ4] Mode 010 captures falling edges only; mode 011 rising edges only.
// [RQ5] Mode 100 captures every 4th rise, mode 101 every 16th rise.
// [RQ6] Mode 111 gives a rising-edge interrupt in sleep or idle only.
// [RQ7] Modes 000 and 110 leave the channel off with no captures.
// [RQ8] Interrupt after every 1st, 2nd, 3rd or 4th capture per field.
// [RQ9] In mode 001 the captures-per-interrupt field is ignored.
// [RQ10] Captured values wait in a four-word first-in first-out buffer.
// [RQ11] Overflow flag, bit 4, is set by hardware and is read-only.
// [RQ12] Buffer flag, bit 3, reads 1 while any captured value is unread.
// [RQ13] Bit 13 high halts the channel while the processor idles; the code halts capture only, and mode 111 still raises its pin interrupt.
// [RQ14] A capture input event can wake the device from sleep and idle.
// [RQ15] Only channels one and two feed DMA, with one capture per interrupt.
// [RQ16] Control bits 15 to 14 and 12 to 8 always read zero.
// [RQ17] Reading the buffer returns and removes the oldest value.
// [RQ18] A capture into a full buffer is lost and sets overflow.
// [RQ19] The pin is synchronised and the prescaler resets on mode change.
module input_capture_channel
  import capture_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  input wire logic capture_input_pin,
  input wire logic [15:0] first_timebase_count,
  input wire logic [15:0] second_timebase_count,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  output logic capture_strobe,
  output logic wake_req,
  output logic irq
);

  // Channel state in one record, the prescaler count aside. Keeping the flops in one struct
  // means a single clock-enable test freezes synchroniser, buffer and flags
  // together, so nothing drifts apart while the enable is low.
  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    ctrl_t ctrl;
    mode_t mode_seen;
    ch_state_t ch;
    logic [FIFO_DEPTH-1:0][15:0] fifo;
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    logic [2:0] level;
    logic ov;
    logic [1:0] cap_cnt;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_en;
    logic [DATA_W-1:0] rdata;
    logic cap_pulse;
    logic wake_pulse;
  } chan_state_t;

  chan_state_t state_reg;
  chan_state_t state_next;

  // Decode a mode code into the channel state it implies.
  // The unused code falls into the default branch, so a stray write of it
  // behaves exactly like turning the channel off.
  function automatic ch_state_t mode_state(input mode_t m);
    case (m)
      MODE_EVERY_EDGE,
      MODE_FALL,
      MODE_RISE,
      MODE_RISE4,
      MODE_RISE16: begin
        mode_state = CH_CAPTURE;
      end
      MODE_INT_PIN: begin
        mode_state = CH_INT_PIN;
      end
      default: begin
        mode_state = CH_OFF; // [RQ7]
      end
    endcase
  endfunction

  // Control register image as software reads it.
  // Fields are placed one by one on a zero word, so every unimplemented
  // position reads zero without a separate mask to keep in step.
  function automatic logic [DATA_W-1:0] ctrl_image(input ctrl_t c,
                                                   input logic ov,
                                                   input logic bne);
    logic [DATA_W-1:0] v;
    v = 16'h0000; // [RQ16]
    v[IDLE_STOP_BIT] = c.idle_stop_select;
    v[TB_SEL_BIT] = c.timebase_select;
    v[CPI_LSB +: 2] = c.captures_per_interrupt;
    v[OV_BIT] = ov;
    v[BNE_BIT] = bne;
    v[MODE_LSB +: 3] = c.capture_mode_select;
    ctrl_image = v;
  endfunction

  logic rise;
  logic fall;
  logic halted;
  logic mode_change;
  logic pre_tick;
  logic edge_hit;
  logic capture;
  logic full;
  logic pop;
  logic push;
  logic cpi_done;
  logic int_capture;
  logic wake_event;
  logic [15:0] stamp;
  logic [INT_W-1:0] int_set;
  logic [INT_W-1:0] int_clr;
  logic [INT_W-1:0] stat_next;
  logic [2:0] level_next;
  logic low_power;
  logic pre_clear;

  // Edge detection works from the second synchroniser stage only.
  // The previous-value flop sits after that stage, so an unsettled first
  // stage can never produce a false edge.
  assign rise = state_reg.pin_sync && !state_reg.pin_prev;
  assign fall = !state_reg.pin_sync && state_reg.pin_prev;

  // Idle stop freezes capture work but not the register port.
  // Pin-interrupt mode ignores the stop bit on purpose, since its whole
  // job is to wake the processor out of idle.
  assign halted = state_reg.ctrl.idle_stop_select && cpu_idle; // [RQ13]
  assign low_power = cpu_idle || cpu_sleep;

  // Any change of mode restarts the prescaler and decimation count.
  assign mode_change = state_reg.ctrl.capture_mode_select != state_reg.mode_seen; // [RQ19]

  // The prescaler is cleared whenever it is not counting for a capture mode.
  // Its enable stays on for a clear even while idle stop holds it, so a mode
  // written during idle still starts a fresh rise count afterwards.
  assign pre_clear = mode_change || (state_reg.ch != CH_CAPTURE); // [RQ19]

  edge_prescaler u_prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce && (!halted || pre_clear)),
    .clear(pre_clear),
    .rise(rise),
    .div16(state_reg.ctrl.capture_mode_select == MODE_RISE16),
    .tick(pre_tick)
  );

  // Qualify edges against the current mode.
  always_comb begin
    case (state_reg.ctrl.capture_mode_select)
      MODE_EVERY_EDGE: begin
        edge_hit = rise || fall; // [RQ3]
      end
      MODE_FALL: begin
        edge_hit = fall; // [RQ4]
      end
      MODE_RISE: begin
        edge_hit = rise; // [RQ4]
      end
      MODE_RISE4,
      MODE_RISE16: begin
        edge_hit = pre_tick; // [RQ5]
      end
      default: begin
        edge_hit = 1'b0; // [RQ7]
      end
    endcase
  end

  // A capture needs a qualified edge in a live capture mode. The cycle in
  // which a new mode takes hold is skipped, as the channel state lags a cycle.
  assign capture = edge_hit && (state_reg.ch == CH_CAPTURE) && !halted && !mode_change;

  // Timebase choice: bit 7 high takes the first counter.
  assign stamp = state_reg.ctrl.timebase_select ? first_timebase_count : second_timebase_count; // [RQ2]

  // Buffer bookkeeping; a pop frees a slot in the same cycle.
  // Three level bits tell a full buffer of four from an empty one, while
  // the two-bit pointers simply wrap around the four slots.
  assign full = state_reg.level == 3'(FIFO_DEPTH);
  assign pop = rd_en && (addr == ADDR_BUFFER) && (state_reg.level != 3'h0); // [RQ17]
  assign push = capture && (!full || pop);
  assign level_next = state_reg.level + 3'(push) - 3'(pop);

  // Decimation; mode 001 interrupts on every capture regardless.
  // The counter restarts on a mode change, so the first interrupt after a
  // new mode always comes after a whole group of captures.
  assign cpi_done = (state_reg.ctrl.capture_mode_select == MODE_EVERY_EDGE) || // [RQ9]
                    (state_reg.cap_cnt == state_reg.ctrl.captures_per_interrupt); // [RQ8]
  assign int_capture = capture && cpi_done;

  // Pin-interrupt mode only answers while the processor sleeps or idles.
  // Outside low power a capture raises only the interrupt status, never
  // the wake pulse, so a running processor sees no spurious wake request.
  assign wake_event = low_power &&
                      ((state_reg.ch == CH_INT_PIN && rise) || // [RQ6]
                       int_capture); // [RQ14]

  // Event and software clear vectors for the interrupt status.
  assign int_set[INT_CAPTURE] = int_capture || (state_reg.ch == CH_INT_PIN && rise && low_power);
  assign int_set[INT_OVERFLOW] = capture && full && !pop;
  assign int_set[INT_WAKE] = wake_event;
  assign int_clr = (wr_en && addr == ADDR_INT_CLEAR) ? wdata[INT_W-1:0] : '0;

  // A new event wins over a clear written in the same cycle.
  genvar gi;
  generate
    for (gi = 0; gi < INT_W; gi++) begin : g_stat
      assign stat_next[gi] = int_set[gi] || (state_reg.int_stat[gi] && !int_clr[gi]);
    end
  endgenerate

  // Next-state computation for the whole channel.
  always_comb begin
    state_next = state_reg;
    state_next.pin_meta = capture_input_pin; // [RQ19]
    state_next.pin_sync = state_reg.pin_meta;
    state_next.pin_prev = state_reg.pin_sync;
    state_next.mode_seen = state_reg.ctrl.capture_mode_select;
    state_next.ch = mode_state(state_reg.ctrl.capture_mode_select);
    state_next.int_stat = stat_next;
    state_next.cap_pulse = 1'b0;
    state_next.wake_pulse = wake_event;
    state_next.rdata = 16'h0000;

    // Control writes; the status bits in the image are ignored, because the
    // overflow and buffer flags belong to the hardware alone.
    if (wr_en && addr == ADDR_CONTROL) begin
      state_next.ctrl.idle_stop_select = wdata[IDLE_STOP_BIT];
      state_next.ctrl.timebase_select = wdata[TB_SEL_BIT];
      state_next.ctrl.captures_per_interrupt = wdata[CPI_LSB +: 2];
      state_next.ctrl.capture_mode_select = mode_t'(wdata[MODE_LSB +: 3]);
    end
    if (wr_en && addr == ADDR_INT_ENABLE) begin
      state_next.int_en = wdata[INT_W-1:0];
    end

    // Register reads answer one cycle later; unmapped reads give zero.
    // A read of an empty buffer returns zero and leaves the pointers alone.
    if (rd_en) begin
      case (addr)
        ADDR_CONTROL: begin
          state_next.rdata = ctrl_image(state_reg.ctrl, state_reg.ov,
                                        state_reg.level != 3'h0); // [RQ12]
        end
        ADDR_BUFFER: begin
          if (pop) begin
            state_next.rdata = state_reg.fifo[state_reg.rd_ptr]; // [RQ17]
          end
        end
        ADDR_INT_STATUS: begin
          state_next.rdata = {{(DATA_W-INT_W){1'b0}}, state_reg.int_stat};
        end
        ADDR_INT_ENABLE: begin
          state_next.rdata = {{(DATA_W-INT_W){1'b0}}, state_reg.int_en};
        end
        default: begin
          state_next.rdata = 16'h0000;
        end
      endcase
    end

    // Oldest entry leaves on a buffer read.
    if (pop) begin
      state_next.rd_ptr = state_reg.rd_ptr + 2'h1;
    end

    // Store the stamp; a full buffer with no pop in the same cycle drops it.
    if (push) begin
      state_next.fifo[state_reg.wr_ptr] = stamp; // [RQ1] [RQ10]
      state_next.wr_ptr = state_reg.wr_ptr + 2'h1;
      state_next.cap_pulse = 1'b1; // [RQ15]
    end
    state_next.level = level_next;

    // Decimation counter steps per capture, wraps at the chosen count.
    if (mode_change) begin
      state_next.cap_cnt = 2'h0;
    end else if (capture) begin
      state_next.cap_cnt = cpi_done ? 2'h0 : state_reg.cap_cnt + 2'h1; // [RQ8]
    end

    // Overflow: set wins; cleared only by emptying or turning off.
    // A flag left over from an earlier burst would otherwise mislead
    // software long after the buffer has been drained.
    if (capture && full && !pop) begin
      state_next.ov = 1'b1; // [RQ18] [RQ11]
    end else if (state_reg.ch == CH_OFF || (pop && level_next == 3'h0)) begin
      state_next.ov = 1'b0; // [RQ18]
    end
  end

  // State register, frozen while the clock enable is low.
  // The reset branch loads constants only; control comes from the package default.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{
        pin_meta: 1'b0,
        pin_sync: 1'b0,
        pin_prev: 1'b0,
        ctrl: CTRL_RESET,
        mode_seen: MODE_OFF,
        ch: CH_OFF,
        fifo: '0,
        wr_ptr: 2'h0,
        rd_ptr: 2'h0,
        level: 3'h0,
        ov: 1'b0,
        cap_cnt: 2'h0,
        int_stat: '0,
        int_en: '0,
        rdata: 16'h0000,
        cap_pulse: 1'b0,
        wake_pulse: 1'b0
      };
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Outputs; the interrupt is a level from registered bits.
  // Gating registered bits only keeps the interrupt line free of glitches.
  assign rdata = state_reg.rdata;
  assign capture_strobe = state_reg.cap_pulse;
  assign wake_req = state_reg.wake_pulse;
  assign irq = |(state_reg.int_stat & state_reg.int_en);

endmodule

// ### verification/capture_chk.sv
/*
  Port checker for the capture channel.
  Assumes ce stays high and reads answer one cycle after the strobe.
*/
`timescale 1ns/1ps
module capture_chk
  import capture_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic capture_input_pin,
  input wire logic [15:0] first_timebase_count,
  input wire logic [15:0] second_timebase_count,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic capture_strobe,
  input wire logic wake_req,
  input wire logic irq
);
  logic [15:0] ctl_reg;
  logic [INT_W-1:0] en_reg;
  logic [2:0] lvl_reg;
  logic [2:0] lvl;
  logic ctl_rd;
  // A strobe marks a store made one cycle earlier, so it joins the level at once.
  assign lvl = lvl_reg + 3'(capture_strobe);
  assign ctl_rd = rd_en && addr == ADDR_CONTROL;
  // Mirror control and enable writes; the level is stores minus pops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= '0;
      en_reg <= '0;
      lvl_reg <= '0;
    end else begin
      if (wr_en && addr == ADDR_CONTROL) ctl_reg <= wdata;
      if (wr_en && addr == ADDR_INT_ENABLE) en_reg <= wdata[INT_W-1:0];
      lvl_reg <= lvl - 3'(rd_en && addr == ADDR_BUFFER && lvl != 3'h0);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_unused_zero: assert property (ctl_rd |=> rdata[15:14] == 2'h0 && rdata[12:8] == 5'h0)
    else $error("unimplemented control bits read nonzero");
  a_bne_level: assert property (ctl_rd |=> rdata[BNE_BIT] == ($past(lvl) != 3'h0))
    else $error("buffer flag disagrees with level");
  a_depth_limit: assert property (lvl == 3'h4 && !rd_en |=> !capture_strobe)
    else $error("store into a full buffer");
  a_off_quiet: assert property (ctl_reg[2:0] inside {3'h0, 3'h6, 3'h7} |=> !capture_strobe)
    else $error("capture while channel is off");
  a_idle_halt: assert property (ctl_reg[IDLE_STOP_BIT] && cpu_idle |=> !capture_strobe)
    else $error("capture while halted in idle");
  a_irq_masked: assert property (en_reg == '0 ##1 en_reg == '0 |-> !irq)
    else $error("interrupt with all enables off");
  a_wake_lowpower: assert property (wake_req |-> $past(cpu_idle || cpu_sleep))
    else $error("wake outside low power");
  a_edge_sync: assert property (capture_strobe |-> $past(capture_input_pin, 3) != $past(capture_input_pin, 4))
    else $error("store without a synchronised edge");
  cover property (capture_strobe);
  cover property (wake_req);
  cover property (lvl == 3'h4);
endmodule

bind input_capture_channel capture_chk chk (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .capture_input_pin(capture_input_pin),
  .first_timebase_count(first_timebase_count), .second_timebase_count(second_timebase_count),
  .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .capture_strobe(capture_strobe), .wake_req(wake_req), .irq(irq));

// ### verification/pin_source.sv
/*
  Model of the external source on the capture pin.
  Assumes req is a one-cycle pulse; delay makes a slow source.
*/
`timescale 1ns/1ps
module pin_source (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [1:0] delay,
  output logic pin
);
  logic [2:0] wait_reg;
  // Each request flips the pin now or some cycles later; the pin idles low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin <= 1'b0;
      wait_reg <= '0;
    end else if (req) begin
      if (delay == 2'h0) pin <= !pin;
      wait_reg <= {1'b0, delay};
    end else if (wait_reg != 3'h0) begin
      wait_reg <= wait_reg - 3'h1;
      if (wait_reg == 3'h1) pin <= !pin;
    end
  end
endmodule

// ### verification/test_input_capture_channel.sv
/*
  Self-checking bench for the capture channel.
  Assumes read data stand only in the cycle after the read strobe.
*/
`timescale 1ns/1ps
module test_input_capture_channel;
  import capture_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] tb1 = '0;
  logic [15:0] tb2 = '0;
  logic cpu_idle = 1'b0;
  logic cpu_sleep = 1'b0;
  logic req = 1'b0;
  logic [1:0] delay = '0;
  logic pin;
  logic [DATA_W-1:0] rdata;
  logic capture_strobe;
  logic wake_req;
  logic irq;
  logic [15:0] offc [3] = '{16'h0080, 16'h0086, 16'h0087};
  int errors = 0;
  int checks_done = 0;
  int strobes = 0;
  int wakes = 0;

  // Free-running clock, 100 ns period.
  always #50 clk = ~clk;

  input_capture_channel DUT (.clk(clk), .rst_n(rst_n), .ce(1'b1), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .capture_input_pin(pin), .first_timebase_count(tb1),
    .second_timebase_count(tb2), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .capture_strobe(capture_strobe), .wake_req(wake_req), .irq(irq));
  pin_source src (.clk(clk), .rst_n(rst_n), .req(req), .delay(delay), .pin(pin));

  // Pulses last one cycle, so they are counted at every edge.
  always @(posedge clk) begin
    if (capture_strobe === 1'b1) strobes++;
    if (wake_req === 1'b1) wakes++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("errors %0d, checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One idle cycle between accesses keeps each strobe a single clean pulse.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] want);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    // Data are taken at the edge closing their cycle, so later stimulus stays on rising edges.
    @(posedge clk);
    check(rdata, want);
  endtask

  // Each pin change gets enough cycles for sync, store and a slow source.
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge clk);
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask

  // A hang counts as a mismatch.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_CONTROL, 16'h0000);
    wr(ADDR_CONTROL, 16'hffff);
    rd(ADDR_CONTROL, 16'h20e7);
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000);
    wr(ADDR_INT_ENABLE, 16'h0007);
    rd(ADDR_INT_ENABLE, 16'h0007);
    // Five rises into a four-deep buffer; falls are ignored.
    wr(ADDR_CONTROL, 16'h0083);
    strobes = 0;
    for (int i = 1; i < 6; i++) begin
      tb1 <= 16'(16'h1234 * i);
      tb2 <= 16'hffff;
      toggle(2);
    end
    check(16'(strobes), 16'h0004);
    rd(ADDR_CONTROL, 16'h009b);
    rd(ADDR_INT_STATUS, 16'h0003);
    for (int i = 1; i < 5; i++) rd(ADDR_BUFFER, 16'(16'h1234 * i));
    rd(ADDR_CONTROL, 16'h0083);
    rd(ADDR_BUFFER, 16'h0000);
    // Slow source, falling mode, second timebase.
    delay <= 2'h3;
    wr(ADDR_CONTROL, 16'h0002);
    tb2 <= 16'hc35a;
    toggle(2);
    delay <= 2'h0;
    rd(ADDR_BUFFER, 16'hc35a);
    rd(ADDR_CONTROL, 16'h0002);
    // Decimation counts captures from the mode change; DMA-style use sets 00.
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CONTROL, 16'h0000);
      wr(ADDR_CONTROL, 16'h0083 | 16'(k << 5));
      wr(ADDR_INT_CLEAR, 16'h0007);
      toggle(2 * k);
      // The clear lands at the edge that ends the write; look one cycle later.
      @(posedge clk);
      check(16'(irq), 16'h0000);
      toggle(2);
      check(16'(irq), 16'h0001);
      repeat (k + 1) rd(ADDR_BUFFER, 16'h5b04);
    end
    // Every-edge mode ignores the decimation field.
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_CONTROL, 16'h00e1);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_INT_CLEAR, 16'h0007);
      toggle(1);
      check(16'(irq), 16'h0001);
    end
    repeat (2) rd(ADDR_BUFFER, 16'h5b04);
    // Prescaled modes keep only every 4th or 16th rise.
    for (int j = 0; j < 2; j++) begin
      wr(ADDR_CONTROL, 16'h0000);
      wr(ADDR_CONTROL, 16'(16'h0084 + j));
      toggle(j ? 30 : 6);
      rd(ADDR_CONTROL, 16'(16'h0084 + j));
      toggle(2);
      rd(ADDR_CONTROL, 16'(16'h008c + j));
      rd(ADDR_BUFFER, 16'h5b04);
    end
    // A direct mode change, with no stop in between, restarts the rise count.
    toggle(4);
    wr(ADDR_CONTROL, 16'h0084);
    toggle(6);
    rd(ADDR_CONTROL, 16'h0084);
    toggle(2);
    rd(ADDR_CONTROL, 16'h008c);
    rd(ADDR_BUFFER, 16'h5b04);
    // Off, unused and pin-interrupt codes store nothing while awake.
    wr(ADDR_INT_CLEAR, 16'h0007);
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CONTROL, offc[m]);
      toggle(2);
      rd(ADDR_CONTROL, offc[m]);
    end
    check(16'({wakes[0], irq}), 16'h0000);
    // In sleep only the rise raises the wake and the interrupt.
    cpu_sleep <= 1'b1;
    toggle(2);
    check(16'(wakes), 16'h0001);
    rd(ADDR_INT_STATUS, 16'h0005);
    rd(ADDR_CONTROL, 16'h0087);
    cpu_sleep <= 1'b0;
    // Idle stop halts capture only with the bit set.
    cpu_idle <= 1'b1;
    wr(ADDR_CONTROL, 16'h2083);
    toggle(2);
    rd(ADDR_CONTROL, 16'h2083);
    wr(ADDR_CONTROL, 16'h0083);
    toggle(2);
    rd(ADDR_CONTROL, 16'h008b);
    rd(ADDR_BUFFER, 16'h5b04);
    cpu_idle <= 1'b0;
    // A masked capture sets status but keeps the line low.
    wr(ADDR_INT_ENABLE, 16'h0000);
    wr(ADDR_INT_CLEAR, 16'h0007);
    toggle(2);
    check(16'(irq), 16'h0000);
    rd(ADDR_INT_STATUS, 16'h0001);
    wr(ADDR_INT_CLEAR, 16'h0001);
    rd(ADDR_INT_STATUS, 16'h0000);
    conclude();
  end
endmodule
